// ---- sac_pkg.sv ----
package sac_pkg;

	// ==================================================
	// register offsets
	localparam logic [7:0] SAC_ACC_CFG_ADDR  = 8'hba;
	localparam logic [7:0] SAC_CONV_CFG_ADDR = 8'hbc;
	localparam logic [7:0] SAC_RES_LOW_ADDR  = 8'hbd;
	localparam logic [7:0] SAC_RES_HIGH_ADDR = 8'hbe;

	// ==================================================
	// reset values
	localparam logic [7:0]  SAC_CONV_CFG_RST = 8'hf8;
	localparam logic [7:0]  SAC_ACC_CFG_RST  = 8'h00;
	localparam logic [15:0] SAC_RESULT_RST   = 16'h0000;

	// ==================================================
	// field positions, converter_config
	localparam int SAC_DIV_MSB   = 7;
	localparam int SAC_DIV_LSB   = 3;
	localparam int SAC_EIGHT_BIT = 2;
	localparam int SAC_DTRACK_BIT = 1;
	localparam int SAC_GAIN_BIT  = 0;

	// field positions, accumulator_config
	localparam int SAC_TWELVE_BIT = 7;
	localparam int SAC_ACCUM_BIT  = 6;
	localparam int SAC_SJ_MSB     = 5;
	localparam int SAC_SJ_LSB     = 3;
	localparam int SAC_RPT_MSB    = 2;
	localparam int SAC_RPT_LSB    = 0;

	// ==================================================
	// widths and timing counts
	localparam int SAC_DIV_W = 5;
	localparam int SAC_CODE_W = 12;
	localparam logic [1:0] SAC_DELAY_TRACK_CYCLES = 2'h3;
	localparam logic [3:0] SAC_CONV_CLOCKS_8  = 4'hb;
	localparam logic [3:0] SAC_CONV_CLOCKS_10 = 4'hd;
	localparam logic [3:0] SAC_CONV_CLOCKS_12 = 4'hd;

	// shift and justify codes
	localparam logic [2:0] SAC_SJ_LEFT = 3'h4;

	// left-justify shifts for each resolution
	localparam logic [3:0] SAC_LJ_SHIFT_8  = 4'h8;
	localparam logic [3:0] SAC_LJ_SHIFT_10 = 4'h6;
	localparam logic [3:0] SAC_LJ_SHIFT_12 = 4'h4;

	typedef enum logic [1:0] {SAC_IDLE, SAC_TRACK, SAC_CONV} sac_state_e;

endpackage

// ---- sac_clk_if.sv ----
`timescale 1ns/1ps
interface sac_clk_if;
	logic       src_tick;
	logic [4:0] divider;
	logic       sar_tick;

	modport div (input src_tick, input divider, output sar_tick);
	modport seq (output src_tick, output divider, input sar_tick);
endinterface

// ---- sac_clk_div.sv ----
`timescale 1ns/1ps
module sac_clk_div (
	input  wire logic mclk,
	input  wire logic srst,
	sac_clk_if.div    clk_bus
);
	import sac_pkg::*;

	logic [SAC_DIV_W-1:0] count;
	logic                 sar_tick;

	// ==================================================
	// divide source ticks by divider + 1
	wire wrap = (count >= clk_bus.divider);

	always_ff @(posedge mclk) begin
		if (srst) begin
			count    <= '0;
			sar_tick <= 1'b0;
		end else begin
			sar_tick <= clk_bus.src_tick & wrap;
			if (clk_bus.src_tick) begin
				count <= wrap ? '0 : count + 5'h01;
			end
		end
	end

	assign clk_bus.sar_tick = sar_tick;
endmodule

// ---- sac_top.sv ----
`timescale 1ns/1ps
module sac_top (
	input  wire logic                       mclk,
	input  wire logic                       srst,
	input  wire logic [7:0]                 sfr_addr,
	input  wire logic                       sfr_wr,
	input  wire logic                       sfr_rd,
	input  wire logic [7:0]                 sfr_wdata,
	output logic      [7:0]                 sfr_rdata,
	input  wire logic                       converter_on,
	input  wire logic                       burst_select,
	input  wire logic                       lpo_tick,
	input  wire logic                       start_conv,
	input  wire logic [sac_pkg::SAC_CODE_W-1:0] adc_code,
	output logic                            conversion_clock,
	output logic                            tracking,
	output logic                            converting,
	output logic                            conv_done,
	output logic                            input_gain_select,
	output logic                            eight_bit_select,
	output logic                            twelve_bit_select
);
	import sac_pkg::*;

	// ==================================================
	// functions
	function automatic logic [6:0] repeat_total(input logic [2:0] code);
		case (code)
			3'h1:    repeat_total = 7'h04;
			3'h2:    repeat_total = 7'h08;
			3'h3:    repeat_total = 7'h10;
			3'h4:    repeat_total = 7'h20;
			3'h5:    repeat_total = 7'h40;
			default: repeat_total = 7'h01;  // reserved codes act as one
		endcase
	endfunction

	function automatic logic [15:0] format_result(input logic [15:0] acc, input logic [2:0] sj,
	                                              input logic [3:0] lj_shift);
		if (sj == SAC_SJ_LEFT) begin
			format_result = acc << lj_shift;
		end else begin
			format_result = acc >> sj[1:0];
		end
	endfunction

	// ==================================================
	// registers
	logic [7:0]  conv_cfg;
	logic [7:0]  acc_cfg;
	logic [15:0] result;
	sac_state_e  state;
	logic [1:0]  track_count;
	logic [3:0]  conv_count;
	logic [6:0]  burst_left;
	logic        first_in_burst;

	sac_clk_if clk_bus ();

	sac_clk_div u_div (
		.mclk    (mclk),
		.srst    (srst),
		.clk_bus (clk_bus)
	);

	// ==================================================
	// field decode
	wire [4:0] sar_clock_divider    = conv_cfg[SAC_DIV_MSB:SAC_DIV_LSB];
	wire       cfg_eight_bit        = conv_cfg[SAC_EIGHT_BIT];
	wire       delayed_track_select = conv_cfg[SAC_DTRACK_BIT];
	wire       cfg_twelve_bit       = acc_cfg[SAC_TWELVE_BIT];
	wire       accumulate_select    = acc_cfg[SAC_ACCUM_BIT];
	wire [2:0] shift_justify_select = acc_cfg[SAC_SJ_MSB:SAC_SJ_LSB];
	wire [2:0] repeat_count         = acc_cfg[SAC_RPT_MSB:SAC_RPT_LSB];

	// ==================================================
	// conversion clock source
	// lpo_tick is an enable from the low-power oscillator block, one mclk wide
	wire divider_source_clock = burst_select ? lpo_tick : 1'b1;

	assign clk_bus.src_tick = divider_source_clock;
	assign clk_bus.divider  = sar_clock_divider;

	wire sar_tick = clk_bus.sar_tick;

	// ==================================================
	// resolution and conversion length
	// twelve-bit takes priority over eight-bit if both are set
	wire [3:0] conv_clocks = cfg_twelve_bit ? SAC_CONV_CLOCKS_12 :
	                         cfg_eight_bit  ? SAC_CONV_CLOCKS_8  : SAC_CONV_CLOCKS_10;
	wire [3:0] lj_shift    = cfg_twelve_bit ? SAC_LJ_SHIFT_12 :
	                         cfg_eight_bit  ? SAC_LJ_SHIFT_8  : SAC_LJ_SHIFT_10;

	// mask the code to the selected resolution
	wire [11:0] code_mask = cfg_twelve_bit ? 12'hfff : cfg_eight_bit ? 12'h0ff : 12'h3ff;
	wire [15:0] sample    = {4'h0, adc_code & code_mask};

	// ==================================================
	// sequencer decode
	wire start_ok    = (state == SAC_IDLE) & start_conv & (converter_on | burst_select);
	wire track_end   = (state == SAC_TRACK) & sar_tick & (track_count == SAC_DELAY_TRACK_CYCLES - 2'h1);
	wire conv_end    = (state == SAC_CONV) & sar_tick & (conv_count == conv_clocks - 4'h1);
	wire more_burst  = burst_select & (burst_left != 7'h00);
	wire after_conv  = delayed_track_select;

	// accumulate versus overwrite
	wire add_mode       = burst_select ? ~first_in_burst : accumulate_select;
	wire [15:0] next_result = add_mode ? result + sample : sample;

	// ==================================================
	// sequencer
	always_ff @(posedge mclk) begin
		if (srst) begin
			state          <= SAC_IDLE;
			track_count    <= 2'h0;
			conv_count     <= 4'h0;
			burst_left     <= 7'h00;
			first_in_burst <= 1'b0;
		end else begin
			case (state)
				SAC_IDLE: begin
					if (start_ok) begin
						burst_left     <= burst_select ? repeat_total(repeat_count) - 7'h01 : 7'h00;
						first_in_burst <= 1'b1;
						track_count    <= 2'h0;
						conv_count     <= 4'h0;
						state          <= delayed_track_select ? SAC_TRACK : SAC_CONV;
					end
				end
				SAC_TRACK: begin
					if (track_end) begin
						state <= SAC_CONV;
					end else if (sar_tick) begin
						track_count <= track_count + 2'h1;
					end
				end
				SAC_CONV: begin
					if (conv_end) begin
						first_in_burst <= 1'b0;
						conv_count     <= 4'h0;
						track_count    <= 2'h0;
						if (more_burst) begin
							burst_left <= burst_left - 7'h01;
							state      <= after_conv ? SAC_TRACK : SAC_CONV;
						end else begin
							state <= SAC_IDLE;
						end
					end else if (sar_tick) begin
						conv_count <= conv_count + 4'h1;
					end
				end
				default: begin
					state <= SAC_IDLE;
				end
			endcase
		end
	end

	// ==================================================
	// register writes
	wire wr_conv_cfg = sfr_wr & (sfr_addr == SAC_CONV_CFG_ADDR);
	wire wr_acc_cfg  = sfr_wr & (sfr_addr == SAC_ACC_CFG_ADDR);
	wire wr_res_low  = sfr_wr & (sfr_addr == SAC_RES_LOW_ADDR);
	wire wr_res_high = sfr_wr & (sfr_addr == SAC_RES_HIGH_ADDR);

	always_ff @(posedge mclk) begin
		if (srst) begin
			conv_cfg <= SAC_CONV_CFG_RST;
			acc_cfg  <= SAC_ACC_CFG_RST;
		end else begin
			if (wr_conv_cfg) begin
				conv_cfg <= sfr_wdata;
			end
			if (wr_acc_cfg) begin
				acc_cfg <= sfr_wdata;
			end
		end
	end

	// a finishing conversion beats a software write in the same cycle
	always_ff @(posedge mclk) begin
		if (srst) begin
			result <= SAC_RESULT_RST;
		end else if (conv_end) begin
			result <= next_result;
		end else begin
			if (wr_res_low) begin
				result[7:0] <= sfr_wdata;
			end
			if (wr_res_high) begin
				result[15:8] <= sfr_wdata;
			end
		end
	end

	// ==================================================
	// register reads
	wire [15:0] result_view = format_result(result, shift_justify_select, lj_shift);
	wire [7:0]  acc_cfg_view = acc_cfg & ~(8'h01 << SAC_ACCUM_BIT);
	wire [7:0]  read_mux = (sfr_addr == SAC_CONV_CFG_ADDR) ? conv_cfg :
	                       (sfr_addr == SAC_ACC_CFG_ADDR)  ? acc_cfg_view :
	                       (sfr_addr == SAC_RES_LOW_ADDR)  ? result_view[7:0] :
	                       (sfr_addr == SAC_RES_HIGH_ADDR) ? result_view[15:8] : 8'h00;

	always_ff @(posedge mclk) begin
		if (srst) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_rd) begin
			sfr_rdata <= read_mux;
		end
	end

	// ==================================================
	// registered outputs
	always_ff @(posedge mclk) begin
		if (srst) begin
			conversion_clock  <= 1'b0;
			tracking          <= 1'b0;
			converting        <= 1'b0;
			conv_done         <= 1'b0;
			input_gain_select <= 1'b0;
			eight_bit_select  <= 1'b0;
			twelve_bit_select <= 1'b0;
		end else begin
			conversion_clock  <= sar_tick;
			tracking          <= (state == SAC_TRACK);
			converting        <= (state == SAC_CONV);
			conv_done         <= conv_end & ~more_burst;
			input_gain_select <= conv_cfg[SAC_GAIN_BIT];
			eight_bit_select  <= cfg_eight_bit & ~cfg_twelve_bit;
			twelve_bit_select <= cfg_twelve_bit;
		end
	end
endmodule

// ---- sac_top_checker.sv ----
`timescale 1ns/1ps
// ====
// port checks: config outputs and conversion timing
module sac_top_checker
	import sac_pkg::*;
(
	input wire logic       mclk,
	input wire logic       srst,
	input wire logic [7:0] sfr_addr,
	input wire logic       sfr_wr,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	input wire logic       converter_on,
	input wire logic       burst_select,
	input wire logic       start_conv,
	input wire logic       conversion_clock,
	input wire logic       tracking,
	input wire logic       converting,
	input wire logic       conv_done,
	input wire logic       input_gain_select,
	input wire logic       eight_bit_select,
	input wire logic       twelve_bit_select
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);

	wire        cw   = sfr_wr && (sfr_addr == SAC_CONV_CFG_ADDR);
	wire        aw   = sfr_wr && (sfr_addr == SAC_ACC_CFG_ADDR);
	wire        go   = start_conv && !tracking && !converting && (converter_on || burst_select);
	logic [4:0] sdiv;
	logic       sdt;
	logic [7:0] gap;
	logic       seen;
	logic [7:0] trk_ticks;
	logic [7:0] cv_ticks;

	// ====
	// shadow of divider and track mode
	always_ff @(posedge mclk) begin
		if (srst) begin
			sdiv <= 5'h1f;
			sdt  <= 1'b0;
		end else if (cw) begin
			sdiv <= sfr_wdata[7:3];
			sdt  <= sfr_wdata[1];
		end
	end

	// tick spacing only trusted once a tick was seen inside a conversion
	always_ff @(posedge mclk) begin
		gap  <= conversion_clock ? 8'h01 : gap + 8'h01;
		seen <= converting && (conversion_clock || seen);
	end

	// ticks counted per phase; cleared whenever the phase is left
	always_ff @(posedge mclk) begin
		if (srst) begin
			trk_ticks <= 8'h00;
			cv_ticks  <= 8'h00;
		end else begin
			trk_ticks <= tracking ? trk_ticks + {7'h00, conversion_clock} : 8'h00;
			cv_ticks  <= converting ? cv_ticks + {7'h00, conversion_clock} : 8'h00;
		end
	end

	// ====
	// properties
	property p_div_sys;
		conversion_clock && seen && !burst_select |-> gap == {3'h0, sdiv} + 8'h01;
	endproperty
	property p_div_lpo;
		conversion_clock && seen && burst_select |-> gap == ({3'h0, sdiv} + 8'h01) << 1;
	endproperty
	property p_normal;
		go && !sdt |-> ##[1:2] converting;
	endproperty
	property p_delay;
		go && sdt |-> ##[1:2] tracking;
	endproperty
	property p_gain;
		cw ##1 !cw |=> input_gain_select == $past(sfr_wdata[SAC_GAIN_BIT], 2);
	endproperty
	property p_eight;
		cw ##1 !cw |=> eight_bit_select == ($past(sfr_wdata[SAC_EIGHT_BIT], 2) && !twelve_bit_select);
	endproperty
	property p_twelve;
		aw ##1 !aw |=> twelve_bit_select == $past(sfr_wdata[SAC_TWELVE_BIT], 2);
	endproperty
	property p_acc_rd;
		sfr_rd && (sfr_addr == SAC_ACC_CFG_ADDR) |=> sfr_rdata[SAC_ACCUM_BIT] == 1'b0;
	endproperty
	property p_track_len;
		$fell(tracking) |-> trk_ticks == 8'h03;
	endproperty
	property p_conv_len;
		$fell(converting) && (!burst_select || sdt) |-> cv_ticks == {4'h0, (twelve_bit_select ? SAC_CONV_CLOCKS_12 :
		                                                eight_bit_select ? SAC_CONV_CLOCKS_8 : SAC_CONV_CLOCKS_10)};
	endproperty
	property p_burst_track;
		burst_select && sdt && $fell(converting) && !$past(conv_done) |-> tracking;
	endproperty

	a_div_sys: assert property (p_div_sys) else $error("divider period wrong");
	a_div_lpo: assert property (p_div_lpo) else $error("burst tick period wrong");
	a_normal: assert property (p_normal) else $error("no immediate convert");
	a_delay: assert property (p_delay) else $error("no tracking phase");
	a_gain: assert property (p_gain) else $error("gain output wrong");
	a_eight: assert property (p_eight) else $error("eight bit output wrong");
	a_twelve: assert property (p_twelve) else $error("twelve bit output wrong");
	a_acc_rd: assert property (p_acc_rd) else $error("accumulate bit read back");
	a_track_len: assert property (p_track_len) else $error("tracking phase length wrong");
	a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
	a_burst_track: assert property (p_burst_track) else $error("no tracking between burst conversions");

	c_burst: cover property (conv_done && burst_select);
	c_single: cover property (conv_done && !burst_select);
	c_track: cover property ($fell(tracking));
endmodule

bind sac_top sac_top_checker u_chk (.mclk(mclk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
	.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .converter_on(converter_on),
	.burst_select(burst_select), .start_conv(start_conv), .conversion_clock(conversion_clock),
	.tracking(tracking), .converting(converting), .conv_done(conv_done),
	.input_gain_select(input_gain_select), .eight_bit_select(eight_bit_select),
	.twelve_bit_select(twelve_bit_select));

// ---- sar_adc_config_accumulator_tb.sv ----
`timescale 1ns/1ps
module sar_adc_config_accumulator_tb;
	import sac_pkg::*;
	logic        mclk, srst, sfr_wr, sfr_rd, converter_on, burst_select, start_conv;
	logic        lpo_tick = 1'b0;
	logic        cck, trk, cnv, done, gain, eight, twelve;
	logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, rv, cfg;
	logic [11:0] adc_code, c;
	logic [15:0] acc, hv;
	int          err_count, samples_checked, i, k, s;

	sac_top DUT (.mclk(mclk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .converter_on(converter_on),
		.burst_select(burst_select), .lpo_tick(lpo_tick), .start_conv(start_conv), .adc_code(adc_code),
		.conversion_clock(cck), .tracking(trk), .converting(cnv), .conv_done(done),
		.input_gain_select(gain), .eight_bit_select(eight), .twelve_bit_select(twelve));

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	// slow oscillator: one pulse every second cycle
	always @(posedge mclk) lpo_tick <= ~lpo_tick;

	// ====
	// tasks
	task automatic wrap_up;
		$display("compares %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [15:0] sv, input logic [15:0] ev);
		samples_checked++;
		if (sv !== ev) begin
			err_count++;
			$display("wrong value at %0t: saw %h expected %h", $time, sv, ev);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		sfr_addr  <= a;
		sfr_wdata <= d;
		sfr_wr    <= 1'b1;
		@(posedge mclk);
		sfr_wr    <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		sfr_addr <= a;
		sfr_rd   <= 1'b1;
		@(posedge mclk);
		sfr_rd   <= 1'b0;
		#1 rv = sfr_rdata;
	endtask
	task automatic rdres;
		rd(SAC_RES_HIGH_ADDR);
		hv[15:8] = rv;
		rd(SAC_RES_LOW_ADDR);
		hv[7:0] = rv;
	endtask
	task automatic conv(input logic [11:0] cv);
		@(posedge mclk);
		adc_code   <= cv;
		start_conv <= 1'b1;
		@(posedge mclk);
		start_conv <= 1'b0;
		for (i = 0; i < 20000 && done !== 1'b1; i++) begin
			@(posedge mclk);
			#1;
		end
		if (i == 20000) begin
			err_count++;
			wrap_up();
		end
		repeat (2) @(posedge mclk);
	endtask
	// left justify moves the code up by 16 minus its resolution
	function automatic logic [15:0] fmt(input logic [15:0] a, input logic [2:0] sj, input int bits);
		return (sj == 3'h4) ? 16'(a << (16 - bits)) : a >> sj[1:0];
	endfunction

	// ====
	// main sequence
	initial begin
		srst = 1'b1;
		{sfr_wr, sfr_rd, converter_on, burst_select, start_conv} = 5'h00;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		adc_code = 12'h000;
		err_count = 0;
		samples_checked = 0;
		s = $urandom(32'h54f4);
		repeat (16) @(posedge mclk);
		srst <= 1'b0;
		rd(SAC_CONV_CFG_ADDR);
		chk(rv, SAC_CONV_CFG_RST);
		rd(SAC_ACC_CFG_ADDR);
		chk(rv, 16'h0);
		rd(8'h55);
		chk(rv, 16'h0);
		@(posedge mclk);
		converter_on <= 1'b1;
		// every mix of 8/10-bit and track mode, small random divider
		for (k = 0; k < 4; k++) begin
			cfg = {5'($urandom_range(3)), 1'(k), 1'(k >> 1), 1'($urandom)};
			wr(SAC_CONV_CFG_ADDR, cfg);
			rd(SAC_CONV_CFG_ADDR);
			chk(rv, cfg);
			chk({eight, gain}, {cfg[2], cfg[0]});
			c = 12'($urandom);
			conv(c);
			rdres();
			chk(hv, c & (cfg[2] ? 12'h0ff : 12'h3ff));
			wr(SAC_ACC_CFG_ADDR, {2'b00, SAC_SJ_LEFT, 3'h0});
			rdres();
			chk(hv, fmt(c & (cfg[2] ? 12'h0ff : 12'h3ff), SAC_SJ_LEFT, cfg[2] ? 8 : 10));
			wr(SAC_ACC_CFG_ADDR, 8'h00);
		end
		wr(SAC_ACC_CFG_ADDR, 8'h80);
		repeat (2) @(posedge mclk);
		#1 chk({twelve, eight}, 2'b10);
		conv(12'($urandom));
		c = 12'($urandom);
		conv(c);
		rdres();
		chk(hv, c);
		wr(SAC_ACC_CFG_ADDR, 8'hc0);
		rd(SAC_ACC_CFG_ADDR);
		chk(rv, 16'h80);
		wr(SAC_RES_HIGH_ADDR, 8'h00);
		wr(SAC_RES_LOW_ADDR, 8'h00);
		acc = 16'h0;
		for (k = 0; k < 3; k++) begin
			c = (k == 0) ? 12'hfff : 12'($urandom);
			conv(c);
			acc = acc + c;
			rdres();
			chk(hv, acc);
		end
		for (k = 0; k < 5; k++) begin
			wr(SAC_ACC_CFG_ADDR, {2'b11, 3'(k), 3'h0});
			rdres();
			chk(hv, fmt(acc, 3'(k), 12));
		end
		@(posedge mclk);
		burst_select <= 1'b1;
		converter_on <= 1'b0;
		for (k = 0; k < 6; k++) begin
			wr(SAC_ACC_CFG_ADDR, {5'h10, 3'(k)});
			c = 12'($urandom);
			conv(c);
			rdres();
			chk(hv, 16'(c * ((k == 0) ? 1 : 2 ** (k + 1))));
		end
		wr(SAC_ACC_CFG_ADDR, 8'h80);
		@(posedge mclk);
		burst_select <= 1'b0;
		wrap_up();
	end
endmodule
